// file: register_bus_datapath.v
`include "datapath_consts.vh"

module register_bus_datapath (
  input  wire        i_clk,           // 100 MHz clock
  input  wire        i_rst_b,         // Async reset, active low
  input  wire        i_start,         // Final manual timing pulse
  input  wire        i_stop,          // Stop at end of cycle
  input  wire        i_recycle,       // Hold last time state
  input  wire        i_lab_mode,      // Laboratory mode, 10-bit pointer
  input  wire [6:0]  i_src_sel,       // Operand enable gates
  input  wire        i_src_invert,    // Complement work register operand
  input  wire        i_carry_insert,  // Carry into adder low bit
  input  wire [1:0]  i_shift_mode,    // Pass, right, left
  input  wire        i_rotate,        // Rotate rather than shift
  input  wire        i_rot_with_ext,  // Chain includes carry extension
  input  wire        i_add_op,        // Two's complement add in progress
  input  wire [5:0]  i_dest_load,     // Destination load enables
  input  wire        i_ext_set,       // Set carry extension
  input  wire        i_ext_clear,     // Clear carry extension
  input  wire        i_mq_load,       // Copy work register to quotient
  input  wire        i_mem_strobe,    // Memory read strobe, async domain
  input  wire [11:0] i_mem_data,      // Memory sense word
  input  wire [11:0] i_io_data,       // I/O bus inbound word
  input  wire        i_io_strobe,     // I/O inbound strobe, async domain
  input  wire [7:0]  i_rx_data,       // Terminal receiver byte
  input  wire        i_rx_valid,      // Terminal byte ready, async domain
  output reg  [11:0] o_work_reg,      // Work register
  output reg         o_carry_ext,     // Carry extension bit
  output reg  [11:0] o_mq,            // Multiplier-quotient
  output reg  [11:0] o_instr_ptr,     // Next instruction pointer
  output reg  [11:0] o_mem_addr,      // Memory address
  output reg  [11:0] o_mem_wdata,     // Write-back pattern
  output reg  [11:0] o_instr_word,    // Instruction holder
  output reg  [11:0] o_io_out,        // I/O outbound buffer
  output reg  [7:0]  o_tx_data,       // Terminal transmit byte
  output reg         o_tx_load,       // Terminal transmit pulse
  output reg  [4:0]  o_time_state,    // One-hot time state
  output reg         o_mem_start,     // Memory cycle start pulse
  output reg         o_running        // Timing cycles active
);

  // ----------------------------------------
  // Internal registers
  // ----------------------------------------
  reg  [11:0] memory_buffer_reg_q;
  reg  [11:0] mem_latch_q;
  reg  [11:0] io_in_q;
  reg  [1:0]  mem_strobe_sync_q;
  reg  [1:0]  io_strobe_sync_q;
  reg  [1:0]  rx_sync_q;
  reg         mem_strobe_d1_q;
  reg         io_strobe_d1_q;
  reg         rx_d1_q;
  reg         rx_pending_q;
  reg  [7:0]  rx_hold_q;
  reg         tx_pending_q;

  // Combinational route from the enable gates to the bus
  wire [4:0]  state;
  wire        run;
  wire [11:0] opnd_a;
  wire [11:0] opnd_b;
  wire [11:0] sum;
  wire        carry_msb;
  reg  [11:0] bus_word;
  reg         shift_out_bit;
  reg         ext_next;
  wire        pulse;

  // ----------------------------------------
  // Time state sequencer
  // ----------------------------------------
  time_state_seq u_seq (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (i_start),
    .i_stop    (i_stop),
    .i_recycle (i_recycle),
    .o_state   (state),
    .o_run     (run)
  );

  // Every clock while running is one time pulse
  assign pulse = run;

  // ----------------------------------------
  // Enable gates: OR of enabled sources
  // ----------------------------------------
  // Work register and pointer feed A, others B, so adds see two operands
  // Unselected sources contribute zeros, so sources on the same operand side OR together
  assign opnd_a =
    ({12{i_src_sel[`SRC_WORK]}} & (i_src_invert ? ~o_work_reg : o_work_reg)) |
    ({12{i_src_sel[`SRC_PTR]}}  & o_instr_ptr);
  assign opnd_b =
    ({12{i_src_sel[`SRC_ADDR]}} & o_mem_addr) |
    ({12{i_src_sel[`SRC_MBUF]}} & memory_buffer_reg_q) |
    ({12{i_src_sel[`SRC_MEM]}}  & mem_latch_q) |
    ({12{i_src_sel[`SRC_IOB]}}  & io_in_q) |
    ({11'h000, i_src_sel[`SRC_CONST_ONE]});

  // ----------------------------------------
  // Adder chain
  // ----------------------------------------
  ripple_adder u_add (
    .i_a            (opnd_a),
    .i_b            (opnd_b),
    .i_carry_insert (i_carry_insert),
    .o_sum          (sum),
    .o_carry_msb    (carry_msb)
  );

  // ----------------------------------------
  // Shift gates onto the register bus
  // ----------------------------------------
  // Fill bit is zero unless a rotate asks for the wrapped or carry bit
  always @* begin
    shift_out_bit = 1'b0;
    if (i_rotate) begin
      if (i_rot_with_ext) begin
        shift_out_bit = o_carry_ext;
      end else if (i_shift_mode == `SHIFT_RIGHT) begin
        shift_out_bit = sum[0];
      end else begin
        shift_out_bit = sum[`WORD_MSB];
      end
    end
    if (i_shift_mode == `SHIFT_RIGHT) begin
      bus_word = {shift_out_bit, sum[11:1]};
    end else if (i_shift_mode == `SHIFT_LEFT) begin
      bus_word = {sum[10:0], shift_out_bit};
    end else begin
      bus_word = sum;
    end
  end

  // ----------------------------------------
  // Carry extension next value
  // ----------------------------------------
  // Explicit set/clear is applied first, so the add toggle flips its result
  // A rotate through the extension overrides the add toggle
  always @* begin
    ext_next = o_carry_ext;
    if (i_ext_clear) begin
      ext_next = 1'b0;
    end
    if (i_ext_set) begin
      ext_next = 1'b1;
    end
    if (i_rotate && i_rot_with_ext && i_shift_mode == `SHIFT_RIGHT) begin
      ext_next = sum[0];
    end else if (i_rotate && i_rot_with_ext && i_shift_mode == `SHIFT_LEFT) begin
      ext_next = sum[`WORD_MSB];
    end else if (i_add_op && carry_msb) begin
      ext_next = ~ext_next;
    end
  end

  // ----------------------------------------
  // Active registers: bus is their only input, except carry extension (from ext_next) and the lab-mode pointer top bits
  // ----------------------------------------
  // Every destination samples the same bus word on the same edge
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_work_reg          <= `WORD_ZERO;
      o_carry_ext         <= 1'b0;
      o_instr_ptr         <= `WORD_ZERO;
      o_mem_addr          <= `WORD_ZERO;
      memory_buffer_reg_q <= `WORD_ZERO;
      o_instr_word        <= `WORD_ZERO;
      o_io_out            <= `WORD_ZERO;
    end else if (pulse) begin
      if (i_dest_load[`DEST_WORK]) begin
        o_work_reg <= bus_word;
      end
      o_carry_ext <= ext_next;
      if (i_dest_load[`DEST_PTR]) begin
        if (i_lab_mode) begin
          o_instr_ptr <= {o_instr_ptr[11:10], bus_word[9:0]};
        end else begin
          o_instr_ptr <= bus_word;
        end
      end
      if (i_dest_load[`DEST_ADDR]) begin
        o_mem_addr <= bus_word;
      end
      if (i_dest_load[`DEST_MBUF]) begin
        memory_buffer_reg_q <= bus_word;
      end
      if (i_dest_load[`DEST_IWORD]) begin
        o_instr_word <= bus_word;
      end
      if (i_dest_load[`DEST_IOB]) begin
        o_io_out <= bus_word;
      end
    end
  end

  // Write-back pattern always mirrors the buffer register
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_wdata <= `WORD_ZERO;
    end else begin
      o_mem_wdata <= memory_buffer_reg_q;
    end
  end

  // ----------------------------------------
  // Quotient register, fed only by work register
  // ----------------------------------------
  // Not gated by the time pulse, so a copy may be taken while stopped
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mq <= `WORD_ZERO;
    end else if (i_mq_load) begin
      o_mq <= o_work_reg;
    end
  end

  // ----------------------------------------
  // Strobe synchronisers and capture latches
  // ----------------------------------------
  // Data words are held stable by the sender around its strobe
  // Edge detect reads only the second stage, never the first
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_strobe_sync_q <= 2'h0;
      io_strobe_sync_q  <= 2'h0;
      rx_sync_q         <= 2'h0;
      mem_strobe_d1_q   <= 1'b0;
      io_strobe_d1_q    <= 1'b0;
      rx_d1_q           <= 1'b0;
      mem_latch_q       <= `WORD_ZERO;
      io_in_q           <= `WORD_ZERO;
      rx_hold_q         <= 8'h00;
      rx_pending_q      <= 1'b0;
    end else begin
      mem_strobe_sync_q <= {mem_strobe_sync_q[0], i_mem_strobe};
      io_strobe_sync_q  <= {io_strobe_sync_q[0], i_io_strobe};
      rx_sync_q         <= {rx_sync_q[0], i_rx_valid};
      mem_strobe_d1_q   <= mem_strobe_sync_q[1];
      io_strobe_d1_q    <= io_strobe_sync_q[1];
      rx_d1_q           <= rx_sync_q[1];
      if (mem_strobe_sync_q[1] && !mem_strobe_d1_q) begin
        mem_latch_q <= i_mem_data;
      end
      // Received byte wins over the I/O word when both arrive
      if (rx_sync_q[1] && !rx_d1_q) begin
        rx_hold_q    <= i_rx_data;
        rx_pending_q <= 1'b1;
      end else if (io_strobe_sync_q[1] && !io_strobe_d1_q) begin
        io_in_q <= i_io_data;
      end else if (rx_pending_q && state[1]) begin
        io_in_q      <= {4'h0, rx_hold_q};
        rx_pending_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Terminal transmit and memory start
  // ----------------------------------------
  // Transmit taken straight from the work register, not via the bus
  // Transmit and timing status lag the internal state by one clock
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_data    <= 8'h00;
      o_tx_load    <= 1'b0;
      tx_pending_q <= 1'b0;
      o_mem_start  <= 1'b0;
      o_time_state <= 5'h01;
      o_running    <= 1'b0;
    end else begin
      tx_pending_q <= i_dest_load[`DEST_IOB] & pulse;
      o_tx_load    <= tx_pending_q;
      if (tx_pending_q) begin
        o_tx_data <= o_work_reg[7:0];
      end
      o_mem_start  <= run & state[0];
      o_time_state <= state;
      o_running    <= run;
    end
  end

endmodule // register_bus_datapath

// file: datapath_consts.vh
`ifndef DATAPATH_CONSTS_VH
`define DATAPATH_CONSTS_VH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define WORD_W          12
`define WORD_MSB        11
`define PTR_LAB_W       10
`define WORD_ZERO       12'h000
`define WORD_ONES       12'hFFF

// ----------------------------------------
// Operand source selects (one bit per source)
// ----------------------------------------
`define SRC_W           7
`define SRC_WORK        0
`define SRC_PTR         1
`define SRC_ADDR        2
`define SRC_MBUF        3
`define SRC_MEM         4
`define SRC_IOB         5
`define SRC_CONST_ONE   6

// ----------------------------------------
// Shift stage modes
// ----------------------------------------
`define SHIFT_W         2
`define SHIFT_PASS      2'h0
`define SHIFT_RIGHT     2'h1
`define SHIFT_LEFT      2'h2

// ----------------------------------------
// Destination load bits
// ----------------------------------------
`define DEST_W          6
`define DEST_WORK       0
`define DEST_PTR        1
`define DEST_ADDR       2
`define DEST_MBUF       3
`define DEST_IWORD      4
`define DEST_IOB        5

// ----------------------------------------
// Time states
// ----------------------------------------
`define NUM_STATES      5

`endif

// file: time_state_seq.v
`include "datapath_consts.vh"

module time_state_seq (
  input  wire       i_clk,        // System clock
  input  wire       i_rst_b,      // Async reset, active low
  input  wire       i_start,      // Last manual timing pulse
  input  wire       i_stop,       // Stop request
  input  wire       i_recycle,    // Hold in last state
  output reg  [4:0] o_state,      // One-hot time state
  output reg        o_run         // Cycles running
);

  // ----------------------------------------
  // Time state ring
  // ----------------------------------------
  localparam [4:0] TS1 = 5'h01;
  localparam [4:0] TS2 = 5'h02;
  localparam [4:0] TS3 = 5'h04;
  localparam [4:0] TS4 = 5'h08;
  localparam [4:0] TS5 = 5'h10;

  // Each enabled clock is one time pulse; stop only at cycle end
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_state <= TS1;
      o_run   <= 1'b0;
    end else if (!o_run) begin
      if (i_start) begin
        o_run   <= 1'b1;
        o_state <= TS2;
      end
    end else begin
      case (o_state)
        TS1: o_state <= TS2;
        TS2: o_state <= TS3;
        TS3: o_state <= TS4;
        TS4: o_state <= TS5;
        TS5: begin
          if (!i_recycle) begin
            o_state <= TS1;
            if (i_stop) o_run <= 1'b0;
          end
        end
        default: o_state <= TS1;
      endcase
    end
  end

endmodule // time_state_seq

// file: ripple_adder.v
`include "datapath_consts.vh"

module ripple_adder (
  input  wire [11:0] i_a,         // Gated operand A
  input  wire [11:0] i_b,         // Gated operand B
  input  wire        i_carry_insert, // Carry into lowest bit
  output wire [11:0] o_sum,       // Sum bits
  output wire        o_carry_msb  // Carry out of top bit
);

  wire [12:0] carry;

  assign carry[0] = i_carry_insert;

  // ----------------------------------------
  // One full adder per bit, carry ripples up
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `WORD_W; gi = gi + 1) begin : g_bit
      assign o_sum[gi]     = i_a[gi] ^ i_b[gi] ^ carry[gi];
      assign carry[gi + 1] = (i_a[gi] & i_b[gi]) | (carry[gi] & (i_a[gi] ^ i_b[gi]));
    end
  endgenerate

  assign o_carry_msb = carry[`WORD_W];

endmodule // ripple_adder

// file: datapath_properties.sv
module datapath_properties (
  input wire        i_clk,        // Clock
  input wire        i_rst_b,      // Reset, active low
  input wire        i_mq_load,    // Quotient copy request
  input wire        i_lab_mode,   // Short pointer mode
  input wire [11:0] o_work_reg,   // Work register
  input wire [11:0] o_mq,         // Quotient register
  input wire [11:0] o_instr_ptr,  // Instruction pointer
  input wire [4:0]  o_time_state, // One-hot time state
  input wire        o_running,    // Cycles active
  input wire        o_mem_start,  // Memory start pulse
  input wire        o_tx_load,    // Transmit pulse
  input wire [7:0]  o_tx_data     // Transmit byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------
  // Helper slices
  // ----------------
  // Slices kept as nets so that past values can be taken whole
  wire [7:0] work_low = o_work_reg[7:0];
  wire [1:0] ptr_top  = o_instr_ptr[11:10];

  // ----------------
  // Properties
  // ----------------
  // One clock domain, every check blocked while reset is low
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  state_onehot_a:
    assert property ($onehot(o_time_state))
    else $error("time state not one-hot");
  ts2_step_a:
    assert property (o_time_state == 5'h02 |=> o_time_state == 5'h04)
    else $error("time state 2 not followed by 3");
  ts3_step_a:
    assert property (o_time_state == 5'h04 |=> o_time_state == 5'h08)
    else $error("time state 3 not followed by 4");
  ts4_step_a:
    assert property (o_time_state == 5'h08 |=> o_time_state == 5'h10)
    else $error("time state 4 not followed by 5");
  idle_hold_a:
    assert property ($changed(o_work_reg) |-> o_running)
    else $error("work register changed while stopped");
  mq_copy_a:
    assert property (i_mq_load |=> o_mq == $past(o_work_reg))
    else $error("quotient did not copy work register");
  mq_hold_a:
    assert property (!i_mq_load |=> $stable(o_mq))
    else $error("quotient changed without copy request");
  lab_keep_a:
    assert property (i_lab_mode |=> ptr_top == $past(ptr_top))
    else $error("pointer top bits changed in short mode");
  mem_ts1_a:
    assert property (o_mem_start |-> o_time_state == 5'h01)
    else $error("memory start outside time state 1");
  mem_spacing_a:
    assert property (o_mem_start |=> !o_mem_start [*4])
    else $error("memory start pulses too close");
  tx_byte_a:
    assert property ($rose(o_tx_load) |-> o_tx_data == $past(work_low))
    else $error("transmit byte not from work register");
endmodule // datapath_properties

bind register_bus_datapath datapath_properties i_datapath_properties (.*);

// file: core_mem_model.sv
module core_mem_model (
  input  wire        i_clk,   // Clock
  input  wire        i_slow,  // Answer one cycle late
  input  wire        i_start, // Memory cycle start
  input  wire [11:0] i_addr,  // Address
  input  wire [11:0] i_wdata, // Write-back pattern
  output logic       o_strobe, // Read strobe
  output logic [11:0] o_data   // Sense word
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] mem [16];
  logic [3:0]  a;

  // ----------------
  // Read then restore
  // ----------------
  // Core read is destructive, so the word comes back from the write pattern
  initial begin
    for (int k = 0; k < 16; k++) mem[k] = 12'hA50 ^ 12'(k);
    o_strobe = 1'b0;
    o_data = 12'h5AF;
    forever begin
      @(posedge i_clk);
      #1;
      if (i_start === 1'b1) begin
        a = i_addr[3:0];
        if (i_slow) @(posedge i_clk);
        #1;
        o_data = mem[a];
        o_strobe = 1'b1;
        repeat (4) @(posedge i_clk);
        #2;
        o_strobe = 1'b0;
        o_data = ~mem[a];  // Stale word must not linger
        mem[a] = i_wdata;
      end
    end
  end
endmodule // core_mem_model

// file: register_bus_datapath_tb.sv
module register_bus_datapath_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------
  // Signals
  // ----------------
  logic        i_clk;
  logic        i_rst_b     = 1'b0;
  logic        i_start     = 1'b0;
  logic        i_stop      = 1'b0;
  logic        i_recycle   = 1'b0;
  logic        i_lab_mode  = 1'b0;
  logic        i_mq_load   = 1'b0;
  logic        i_io_strobe = 1'b0;
  logic        i_rx_valid  = 1'b0;
  logic        mem_slow    = 1'b0;
  logic [11:0] i_io_data   = 12'h000;
  logic [7:0]  i_rx_data   = 8'h00;
  logic [5:0]  i_dest_load = 6'h00;
  logic [15:0] ctl         = 16'h0000;
  wire  [6:0]  i_src_sel;
  wire  [1:0]  i_shift_mode;
  wire         i_src_invert, i_carry_insert, i_rotate, i_rot_with_ext, i_add_op;
  wire         i_ext_set, i_ext_clear, i_mem_strobe;
  wire  [11:0] i_mem_data;
  wire  [11:0] o_work_reg, o_mq, o_instr_ptr, o_mem_addr, o_mem_wdata, o_instr_word, o_io_out;
  wire  [7:0]  o_tx_data;
  wire  [4:0]  o_time_state;
  wire         o_carry_ext, o_tx_load, o_mem_start, o_running;
  int          fails, checks_done;
  logic [11:0] ew = 12'h000;
  logic [11:0] ep = 12'h000;
  logic        el = 1'b0;
  logic [9:0]  alu_ops [20] = '{10'h000, 10'h300, 10'h284, 10'h201, 10'h202, 10'h203,
    10'h280, 10'h238, 10'h258, 10'h201, 10'h250, 10'h230, 10'h230, 10'h240, 10'h280,
    10'h220, 10'h300, 10'h284, 10'h300, 10'h284};

  // One control word keeps every operation a single table entry
  assign {i_src_sel, i_src_invert, i_carry_insert, i_shift_mode, i_rotate, i_rot_with_ext,
          i_add_op, i_ext_set, i_ext_clear} = ctl;

  register_bus_datapath i_register_bus_datapath (.*);
  core_mem_model i_core_mem_model (.i_clk(i_clk), .i_slow(mem_slow), .i_start(o_mem_start),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_strobe(i_mem_strobe), .o_data(i_mem_data));

  // Free-running clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----------------
  // Helpers
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (o_running !== lvl && n < 20) begin
      tick(1);
      n++;
    end
    chk(o_running, lvl, "running level");
  endtask

  // One transfer for one edge; reference gives work, carry extension, pointer
  task automatic op(input logic [9:0] c, input logic [5:0] d, input logic [6:0] sb = 7'h00,
                    input logic [11:0] eb = 12'h000);
    logic [12:0] s;
    logic [11:0] r;
    logic        l;
    s = {1'b0, c[9] ? (c[8] ? ~ew : ew) : 12'h000} + {1'b0, eb} + {12'h000, c[7]};
    l = c[1] | (el & ~c[0]);
    l = l ^ (c[2] & s[12]);
    r = s[11:0];
    if (c[6:5] == 2'h1) r = {c[4] & (c[3] ? el : s[0]), s[11:1]};
    if (c[6:5] == 2'h2) r = {s[10:0], c[4] & (c[3] ? el : s[11])};
    if (c[4] & c[3] & (c[6:5] == 2'h1)) l = s[0];
    if (c[4] & c[3] & (c[6:5] == 2'h2)) l = s[11];
    tick(1);
    ctl = {sb[6:1], c};
    i_dest_load = d;
    tick(1);
    ctl = 16'h0000;
    i_dest_load = 6'h00;
    if (d[0]) ew = r;
    if (d[1]) ep = i_lab_mode ? {ep[11:10], r[9:0]} : r;
    el = l;
    chk({o_carry_ext, o_instr_ptr, o_work_reg}, {el, ep, ew}, "ext ptr work");
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_run;
    logic [4:0] st;
    st = 5'h02;
    chk({o_work_reg, o_time_state, o_running}, {12'h000, 5'h01, 1'b0}, "reset");
    tick(1);
    i_start = 1'b1;
    ctl = 16'h0280;
    i_dest_load = 6'h01;
    tick(1);
    i_start = 1'b0;
    wait_run(1'b1);
    for (int k = 1; k <= 7; k++) begin
      chk({o_time_state, o_work_reg}, {st, 12'(k)}, "state and count");
      st = {st[3:0], st[4]};
      tick(1);
    end
    ctl = 16'h0000;
    i_dest_load = 6'h00;
    ew = 12'h008;
    $display("start and count test done");
  endtask

  task automatic t_alu;
    foreach (alu_ops[k]) op(alu_ops[k], 6'h01);
    op(10'h300, 6'h03);
    i_mq_load = 1'b1;
    tick(1);
    i_mq_load = 1'b0;
    chk(o_mq, ew, "quotient copy");
    i_lab_mode = 1'b1;
    op(10'h000, 6'h03);
    i_lab_mode = 1'b0;
    $display("shift, carry and pointer test done");
  endtask

  task automatic t_mem;
    mem_slow = 1'b1;
    op(10'h2C0, 6'h0D);
    chk(o_mem_addr, 12'h002, "address");
    tick(25);
    chk(o_mem_wdata, 12'h002, "write pattern");
    op(10'h000, 6'h11, 7'h10, 12'h002);
    chk(o_instr_word, 12'h002, "instruction word");
    op(10'h000, 6'h01, 7'h0E, 12'hC02);
    op(10'h200, 6'h01, 7'h40, 12'h001);
    mem_slow = 1'b0;
    $display("memory test done");
  endtask

  task automatic t_io;
    int n;
    n = 0;
    op(10'h200, 6'h20);
    chk(o_io_out, ew, "io out");
    while (o_tx_load !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk({o_tx_load, o_tx_data}, {1'b1, ew[7:0]}, "tx byte");
    i_rx_data = 8'hA5;
    i_rx_valid = 1'b1;
    tick(10);
    i_rx_valid = 1'b0;
    i_rx_data = 8'h5A;
    op(10'h000, 6'h01, 7'h20, 12'h0A5);
    i_io_data = 12'h3C6;
    i_io_strobe = 1'b1;
    tick(10);
    i_io_strobe = 1'b0;
    i_io_data = 12'hC39;
    op(10'h000, 6'h01, 7'h20, 12'h3C6);
    $display("io test done");
  endtask

  task automatic t_stop;
    i_recycle = 1'b1;
    tick(8);
    chk(o_time_state, 5'h10, "recycle hold");
    i_recycle = 1'b0;
    i_stop = 1'b1;
    wait_run(1'b0);
    i_stop = 1'b0;
    chk(o_time_state, 5'h01, "idle state");
    ctl = 16'h0280;
    i_dest_load = 6'h01;
    tick(3);
    ctl = 16'h0000;
    i_dest_load = 6'h00;
    chk(o_work_reg, ew, "load while stopped");
    $display("stop test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence, reset held three cycles
  initial begin
    tick(3);
    i_rst_b = 1'b1;
    t_run;
    t_alu;
    t_mem;
    t_io;
    t_stop;
    wrap_up;
  end

  // Watchdog, well beyond the hundred-odd cycles the tests need
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule // register_bus_datapath_tb
